// ===== verif/ref_clock_mcu.sv
`timescale 1ns/1ps
// --------------------------------
// mcu timing the reference clock
// --------------------------------
module ref_clock_mcu (
  input  wire logic mclk,
  input  wire logic ref_out_pin,
  output int        period,
  output int        high_len,
  output int        rises
);
  int   cnt;
  int   hcnt;
  logic last;
  initial begin
    {cnt, hcnt, period, high_len, rises} = '0;
    last = 1'b0;
  end
  // sampled on the crystal clock: only whole-cycle figures are seen
  always @(posedge mclk) begin
    last <= ref_out_pin;
    cnt  <= (ref_out_pin && !last) ? 1 : cnt + 1;
    hcnt <= ref_out_pin ? hcnt + 1 : 0;
    if (ref_out_pin && !last) period <= cnt;
    if (ref_out_pin && !last) rises <= rises + 1;
    if (!ref_out_pin && last) high_len <= hcnt;
  end
endmodule : ref_clock_mcu

// ===== verif/synth_ref_clock_control_bench.sv
`timescale 1ns/1ps
module synth_ref_clock_control_bench import synth_ref_pkg::*; ;
  logic        mclk, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, sleep_state, tx_burst;
  logic        data_bit, blocks_enable, osc_bias_high, osc_bias_boost, ref_out_pin;
  logic        internal_load_cap_enable, band_select, vco_div_by_four, oscillator_bypass;
  logic        pump_current_high, closed_loop_mod, open_loop_mod, divider_mod, pll_active;
  logic        divider_set_second, hold_amp_enable;
  logic [2:0]  oscillator_bias_bits;
  logic [3:0]  wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  int          fail_count, tests_run, edges, period, high_len, rises, r0;
  synth_ref_clock_control #(.REFDIV_INIT(REFDIV_RESET)) u_dut (
    .mclk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .sleep_state, .tx_burst, .data_bit, .blocks_enable,
    .osc_bias_high, .osc_bias_boost, .internal_load_cap_enable, .ref_out_pin,
    .band_select, .vco_div_by_four, .oscillator_bias_bits, .oscillator_bypass,
    .pump_current_high, .closed_loop_mod, .open_loop_mod, .divider_mod, .pll_active,
    .divider_set_second, .hold_amp_enable
  );
  ref_clock_mcu u_mcu (.mclk, .ref_out_pin, .period, .high_len, .rises);
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) edges <= rstn ? edges + 1 : 0;
  // --------------------------------
  // shared tasks
  // --------------------------------
  task automatic report_and_stop();
    if (fail_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
  endtask : tick
  // waits for boost off (sel 0) or blocks enabled (sel 1)
  task automatic await(input int sel);
    int k;
    k = 0;
    while ((sel == 0 ? osc_bias_boost !== 1'b0 : blocks_enable !== 1'b1) && k < 100) begin
      @(posedge mclk);
      k++;
    end
    if (k >= 100) check(32'h0, 32'h1);
    if (k >= 100) report_and_stop();
  endtask : await
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge mclk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    if (k >= 20) check(32'h0, 32'h1);
    if (k >= 20) report_and_stop();
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge mclk);
  endtask : bus
  // --------------------------------
  // scenarios
  // --------------------------------
  task automatic t_startup();
    bus(0, ADDR_CTRL, 0);
    check(rd, 0);
    bus(0, ADDR_REFDIV, 0);
    check(rd, 32'(REFDIV_RESET));
    bus(0, 4'h2, 0);
    check(rd, 0);
    bus(1, ADDR_CTRL, 32'h0000_0007);
    tick(2);
    check(32'({internal_load_cap_enable, osc_bias_high, osc_bias_boost}), 7);
    await(0);
    check(32'({edges >= 15 && edges <= 18, blocks_enable}), 2);
    await(1);
    check(32'(edges >= 31 && edges <= 35), 1);
  endtask : t_startup
  task automatic t_refout();
    r0 = rises;
    tick(40);
    check(32'({ref_out_pin, rises == r0}), 1);
    bus(1, ADDR_CTRL, 32'h0000_000B);
    tick(70);
    check(32'({period[7:0], high_len[7:0]}), 32'h1008);
    sleep_state <= 1'b1;
    tick(3);
    r0 = rises;
    tick(40);
    check(32'({ref_out_pin, rises == r0}), 1);
    sleep_state <= 1'b0;
    tick(40);
    check(32'(rises > r0), 1);
    bus(1, ADDR_CTRL, 32'h0000_0003);
    tick(3);
    r0 = rises;
    tick(40);
    check(32'({ref_out_pin, rises == r0}), 1);
  endtask : t_refout
  task automatic t_bias();
    logic [2:0] auto_bias [4] = '{3'h7, 3'h5, 3'h3, 3'h0};
    for (int r = 0; r < 4; r++) begin
      bus(1, ADDR_VCO, 32'(r) << 4);
      tick(2);
      check(32'(oscillator_bias_bits), 32'(auto_bias[r]));
    end
    bus(1, ADDR_VCO, 32'h0000_0032);
    tick(2);
    check(32'(oscillator_bias_bits), 2);
  endtask : t_bias
  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      bus(1, ADDR_CTRL, (32'(m) << 7) | (m[0] ? 32'h50 : 32'h221));
      tx_burst <= 1'b1;
      data_bit <= 1'b1;
      tick(4);
      check(32'({closed_loop_mod, open_loop_mod, divider_mod}), m == 3 ? 0 : 4 >> m);
      check(32'({pll_active, divider_set_second}), {m != 1, m == 2});
      check(32'({band_select, vco_div_by_four, pump_current_high, oscillator_bypass,
                 hold_amp_enable, internal_load_cap_enable}), m[0] ? 32'h28 : 32'h17);
      data_bit <= 1'b0;
      tx_burst <= 1'b0;
      tick(4);
      check(32'({pll_active, divider_set_second}), 2);
    end
  endtask : t_modes
  initial begin
    {mclk, rstn, wb_cyc_i, wb_stb_i, wb_we_i, sleep_state, tx_burst, data_bit} = '0;
    {wb_adr_i, wb_dat_i, fail_count, tests_run, edges} = '0;
    wb_sel_i = 4'h3;
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    t_startup();
    t_refout();
    t_bias();
    t_modes();
    report_and_stop();
  end
endmodule : synth_ref_clock_control_bench

// ===== verif/synth_ref_clock_control_chk.sv
`timescale 1ns/1ps
module synth_ref_chk #(
  parameter int REFDIV_INIT = 16
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic sleep_state,
  input wire logic tx_burst,
  input wire logic blocks_enable,
  input wire logic osc_bias_boost,
  input wire logic ref_out_pin,
  input wire logic band_select,
  input wire logic vco_div_by_four,
  input wire logic open_loop_mod,
  input wire logic divider_mod,
  input wire logic pll_active,
  input wire logic divider_set_second
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // --------------------------------
  // edges since reset release
  // --------------------------------
  logic [15:0] up_cnt;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) up_cnt <= 16'h0000;
    else if (up_cnt != 16'hFFFF) up_cnt <= up_cnt + 16'h0001;
  end
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack after request");
  a_enable_late: assert property ($rose(blocks_enable) |-> int'(up_cnt) >= 2*REFDIV_INIT-1)
    else $error("blocks enabled early");
  a_enable_holds: assert property (blocks_enable |=> blocks_enable)
    else $error("blocks enable dropped");
  a_boost_gone: assert property (blocks_enable |-> !osc_bias_boost)
    else $error("boost still on");
  a_sleep_low: assert property (sleep_state |=> !ref_out_pin)
    else $error("clock out in sleep");
  a_high_eight: assert property (ref_out_pin [*8] |=> !ref_out_pin)
    else $error("clock out high too long");
  a_low_before_rise: assert property ($rose(ref_out_pin) |-> !$past(ref_out_pin, 8))
    else $error("clock out period short");
  a_band_divide: assert property (vco_div_by_four != band_select)
    else $error("band divider wrong");
  a_open_burst: assert property ((open_loop_mod && tx_burst) [*2] |-> !pll_active)
    else $error("loop on in open burst");
  a_loop_idle: assert property (((!tx_burst) [*2] ##0 up_cnt != 16'h0000) |-> pll_active)
    else $error("loop off outside burst");
  a_first_set: assert property ((!divider_mod) [*4] |-> !divider_set_second)
    else $error("second set outside divider mode");
endmodule : synth_ref_chk

bind synth_ref_clock_control synth_ref_chk #(.REFDIV_INIT(REFDIV_INIT)) u_chk (
  .mclk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .sleep_state, .tx_burst, .blocks_enable,
  .osc_bias_boost, .ref_out_pin, .band_select, .vco_div_by_four, .open_loop_mod,
  .divider_mod, .pll_active, .divider_set_second
);

// ===== verilog/synth_ref_clock_control.sv
// The address map and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
// How it works
// R01 - keep other blocks disabled until reference divider gave two pulses, then enable
// R02 - with quick start set, boost oscillator bias at start-up until first divider pulse
// R03 - software should enable crystal oscillator before any other block to save current
// R04 - reference clock output runs only while its enable bit is high
// R05 - reference clock output equals crystal clock divided by sixteen
// R06 - reference clock output is off during sleep regardless of enable bit
// R07 - disabled reference clock output is held low, never floating
// R08 - internal crystal load capacitors connect only when their enable bit is one
// R09 - oscillator divided by two in high band, by four in low band
// R10 - bias bits all zero selects bias automatically from the range bits
// R11 - any bias bit set makes the programmed bias win over automatic
// R12 - automatic bias: range 00,01,10,11 gives 111,101,011,000
// R13 - bypass bit one takes local oscillator from external differential input
// R14 - pump high-current bit selects pump current; resets to zero, low current
// R15 - mode code 00 closed loop, 01 open loop, 10 divider, 11 unused
// R16 - open loop mode turns the loop off during the transmit burst
// R17 - divider mode switches divider set at each new data bit, forcing relock
// R18 - divider mode: first set means data zero, second set data one
// R19 - hold amplifier enabled only while its enable bit is one
// R20 - band bit zero picks low range, one picks high range
// R21 - both oscillator modulation modes use only the first divider set
// R22 - clock output divider free-runs, cleared while disabled, near equal high and low
module synth_ref_clock_control
  import synth_ref_pkg::*;
#(
  parameter int                      REFDIV_WIDTH = REFDIV_W,
  parameter logic [REFDIV_W-1:0]     REFDIV_INIT  = REFDIV_RESET
) (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        sleep_state,
  input  wire logic        tx_burst,
  input  wire logic        data_bit,
  output logic             blocks_enable,
  output logic             osc_bias_high,
  output logic             osc_bias_boost,
  output logic             internal_load_cap_enable,
  output logic             ref_out_pin,
  output logic             band_select,
  output logic             vco_div_by_four,
  output logic      [2:0]  oscillator_bias_bits,
  output logic             oscillator_bypass,
  output logic             pump_current_high,
  output logic             closed_loop_mod,
  output logic             open_loop_mod,
  output logic             divider_mod,
  output logic             pll_active,
  output logic             divider_set_second,
  output logic             hold_amp_enable
);

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic logic [2:0] auto_bias(input logic [1:0] range);
    case (range)
      2'b00:   auto_bias = 3'h7;
      2'b01:   auto_bias = 3'h5;
      2'b10:   auto_bias = 3'h3;
      default: auto_bias = 3'h0;
    endcase
  endfunction : auto_bias

  function automatic logic byte_wr(input logic [3:0] sel, input int lane);
    byte_wr = sel[lane];
  endfunction : byte_wr

  // ---------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------
  logic [CTRL_W-1:0]       ctrl;
  logic [2:0]              bias_prog;
  logic [1:0]              range_prog;
  logic [REFDIV_WIDTH-1:0] refdiv;
  logic [REFDIV_WIDTH-1:0] refdiv_cnt;
  logic [REF_OUT_CNT_W-1:0] ref_cnt;
  logic                    ref_pulse;
  startup_state_e          st;
  startup_state_e          next_st;
  logic                    bit_set;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_wr    = bus_req & wb_we_i;
  wire hit_ctrl  = wb_adr_i == ADDR_CTRL;
  wire hit_vco   = wb_adr_i == ADDR_VCO;
  wire hit_div   = wb_adr_i == ADDR_REFDIV;
  wire hit_stat  = wb_adr_i == ADDR_STATUS;
  wire wr_lane0  = byte_wr(wb_sel_i, 0);
  wire wr_lane1  = byte_wr(wb_sel_i, 1);

  // ---------------------------------------------------------------
  // decoded settings
  // ---------------------------------------------------------------
  wire       mode_lo     = ctrl[CTRL_MOD_LO];
  wire       mode_hi     = ctrl[CTRL_MOD_HI];
  wire [1:0] mode        = {mode_hi, mode_lo};
  wire       ref_out_on  = ctrl[CTRL_REF_OUT] & ~sleep_state;   // see R04 see R06
  wire       bias_forced = |bias_prog;                          // see R11
  wire [2:0] bias_eff    = bias_forced ? bias_prog : auto_bias(range_prog); // see R10 see R12
  wire [REFDIV_WIDTH-1:0] refdiv_last = (refdiv == '0) ? '0 : refdiv - 1'b1;

  wire [31:0] stat_word = {22'h0,
                           ref_out_on,
                           pll_active,
                           divider_set_second,
                           bias_eff,
                           osc_bias_boost,
                           blocks_enable,
                           st};

  // ---------------------------------------------------------------
  // wishbone slave: one wait state, unmapped reads give zero
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= hit_ctrl ? {{(32-CTRL_W){1'b0}}, ctrl} :
                  hit_vco  ? {26'h0, range_prog, 1'b0, bias_prog} :
                  hit_div  ? {{(32-REFDIV_WIDTH){1'b0}}, refdiv} :
                  hit_stat ? stat_word : 32'h0;
    end
  end

  // ---------------------------------------------------------------
  // writable registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl       <= CTRL_RESET;                                 // see R14
      bias_prog  <= VCO_BIAS_RESET;
      range_prog <= VCO_RANGE_RESET;
      refdiv     <= REFDIV_INIT;
    end else if (bus_wr) begin
      if (hit_ctrl && wr_lane0) begin
        ctrl[7:0] <= wb_dat_i[7:0];
      end
      if (hit_ctrl && wr_lane1) begin
        ctrl[CTRL_W-1:8] <= wb_dat_i[CTRL_W-1:8];
      end
      if (hit_vco && wr_lane0) begin
        bias_prog  <= wb_dat_i[VCO_BIAS_LSB +: 3];
        range_prog <= wb_dat_i[VCO_RANGE_LSB +: 2];
      end
      if (hit_div && wr_lane0) begin
        refdiv[7:0] <= wb_dat_i[7:0];
      end
      if (hit_div && wr_lane1) begin
        refdiv[REFDIV_WIDTH-1:8] <= wb_dat_i[REFDIV_WIDTH-1:8];
      end
    end
  end

  // ---------------------------------------------------------------
  // reference divider: one pulse every refdiv crystal clocks
  // ---------------------------------------------------------------
  // a zero divide value acts as one so the start-up never stalls
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      refdiv_cnt <= '0;
      ref_pulse  <= 1'b0;
    end else begin
      ref_pulse  <= refdiv_cnt >= refdiv_last;
      refdiv_cnt <= (refdiv_cnt >= refdiv_last) ? '0 : refdiv_cnt + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // start-up sequencer
  // ---------------------------------------------------------------
  // software is expected to start the oscillator first; this block
  // runs as soon as the crystal clock does  see R03
  always_comb begin
    next_st = st;
    case (st)
      ST_WAIT_FIRST:  if (ref_pulse) next_st = ST_WAIT_SECOND;  // see R02
      ST_WAIT_SECOND: if (ref_pulse) next_st = ST_RUNNING;      // see R01
      ST_RUNNING:     next_st = ST_RUNNING;
      default:        next_st = ST_WAIT_FIRST;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st <= ST_WAIT_FIRST;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // reference clock output divider
  // ---------------------------------------------------------------
  // counter clears while off so the first period after enable is whole
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ref_cnt <= '0;
    end else if (ref_out_on) begin
      ref_cnt <= ref_cnt + 1'b1;                                // see R05 see R22
    end else begin
      ref_cnt <= '0;                                            // see R22
    end
  end

  // ---------------------------------------------------------------
  // divider-set selection follows each new data bit
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bit_set  <= 1'b0;
    end else begin
      bit_set  <= data_bit;                                     // see R17 see R18
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      blocks_enable            <= 1'b0;
      osc_bias_high            <= 1'b0;
      osc_bias_boost           <= 1'b0;
      internal_load_cap_enable <= 1'b0;
      ref_out_pin              <= 1'b0;
      band_select              <= 1'b0;
      vco_div_by_four          <= 1'b1;
      oscillator_bias_bits     <= 3'h0;
      oscillator_bypass        <= 1'b0;
      pump_current_high        <= 1'b0;
      closed_loop_mod          <= 1'b0;
      open_loop_mod            <= 1'b0;
      divider_mod              <= 1'b0;
      pll_active               <= 1'b0;
      divider_set_second       <= 1'b0;
      hold_amp_enable          <= 1'b0;
    end else begin
      blocks_enable            <= next_st == ST_RUNNING;        // see R01
      osc_bias_high            <= ctrl[CTRL_BIAS_HIGH];
      osc_bias_boost           <= ctrl[CTRL_BOOST] && next_st == ST_WAIT_FIRST; // see R02
      internal_load_cap_enable <= ctrl[CTRL_LOAD_CAP];          // see R08
      ref_out_pin              <= ref_out_on & ref_cnt[REF_OUT_CNT_W-1]; // see R07
      band_select              <= ctrl[CTRL_BAND];              // see R20
      vco_div_by_four          <= ~ctrl[CTRL_BAND];             // see R09
      oscillator_bias_bits     <= bias_eff;                     // see R10 see R11
      oscillator_bypass        <= ctrl[CTRL_BYPASS];            // see R13
      pump_current_high        <= ctrl[CTRL_PUMP_HIGH];         // see R14
      closed_loop_mod          <= mode == MOD_CLOSED_LOOP;      // see R15
      open_loop_mod            <= mode == MOD_OPEN_LOOP;        // see R15
      divider_mod              <= mode == MOD_DIVIDER;          // see R15
      pll_active               <= !(mode == MOD_OPEN_LOOP && tx_burst); // see R16
      divider_set_second       <= (mode == MOD_DIVIDER) & bit_set; // see R18 see R21
      hold_amp_enable          <= ctrl[CTRL_HOLD_AMP];          // see R19
    end
  end

endmodule : synth_ref_clock_control

// ===== verilog/synth_ref_pkg.sv
package synth_ref_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_VCO    = 4'h4;
  localparam logic [3:0] ADDR_REFDIV = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hC;

  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  localparam int CTRL_LOAD_CAP   = 0;
  localparam int CTRL_BIAS_HIGH  = 1;
  localparam int CTRL_BOOST      = 2;
  localparam int CTRL_REF_OUT    = 3;
  localparam int CTRL_BAND       = 4;
  localparam int CTRL_BYPASS     = 5;
  localparam int CTRL_PUMP_HIGH  = 6;
  localparam int CTRL_MOD_LO     = 7;
  localparam int CTRL_MOD_HI     = 8;
  localparam int CTRL_HOLD_AMP   = 9;
  localparam int CTRL_W          = 10;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h000;

  // ---------------------------------------------------------------
  // oscillator register fields
  // ---------------------------------------------------------------
  localparam int VCO_BIAS_LSB  = 0;
  localparam int VCO_RANGE_LSB = 4;
  localparam logic [2:0] VCO_BIAS_RESET  = 3'h0;
  localparam logic [1:0] VCO_RANGE_RESET = 2'h0;

  // ---------------------------------------------------------------
  // reference divider and status fields
  // ---------------------------------------------------------------
  localparam int REFDIV_W = 12;
  localparam logic [REFDIV_W-1:0] REFDIV_RESET = 12'h010;
  localparam int STAT_STATE_LSB  = 0;
  localparam int STAT_ENABLE     = 2;
  localparam int STAT_BOOST      = 3;
  localparam int STAT_BIAS_LSB   = 4;
  localparam int STAT_SECOND_SET = 7;
  localparam int STAT_PLL_ACTIVE = 8;
  localparam int STAT_REF_OUT_ON = 9;

  // ---------------------------------------------------------------
  // timing: start-up pulse count and clock output ratio
  // ---------------------------------------------------------------
  localparam int STARTUP_PULSES = 2;
  localparam int REF_OUT_RATIO  = 16;
  localparam int REF_OUT_CNT_W  = $clog2(REF_OUT_RATIO);

  // ---------------------------------------------------------------
  // enumerations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MOD_CLOSED_LOOP = 2'b00,
    MOD_OPEN_LOOP   = 2'b01,
    MOD_DIVIDER     = 2'b10,
    MOD_UNUSED      = 2'b11
  } mod_mode_e;

  typedef enum logic [1:0] {
    ST_WAIT_FIRST  = 2'b00,
    ST_WAIT_SECOND = 2'b01,
    ST_RUNNING     = 2'b10
  } startup_state_e;

endpackage : synth_ref_pkg
